/* File: aps_apb_regs.sv */
// APB register file with interrupt status and mask.
`timescale 1ns/1ns
`default_nettype none
`include "aps_regs.svh"

module aps_apb_regs
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Block side
  input  wire logic [31:0]            status_word,
  input  wire logic [`APS_IRQ_W-1:0]  events,
  output var  logic                   run_en,
  output var  logic                   irq
);

  logic [31:0]            ctrl_q, ctrl_d;
  logic [`APS_IRQ_W-1:0]  ist_q, ist_d, msk_q, msk_d;
  logic [31:0]            rd_q, rd_d;
  logic                   rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
  logic                   acc;

  // True for the four mapped word addresses.
  function automatic logic mapped(input logic [11:0] a);
    return a == `APS_CTRL_OFS || a == `APS_STATUS_OFS ||
           a == `APS_IRQ_STAT_OFS || a == `APS_IRQ_MASK_OFS;
  endfunction

  // Every access completes in the second access-phase cycle; pready is a pulse.
  assign acc = psel && penable && !rdy_q;

  // Next values; an event arriving with a write-one-clear still sets.
  always_comb
  begin
    ctrl_d = ctrl_q;
    msk_d  = msk_q;
    ist_d  = ist_q;
    rd_d   = 32'h0000_0000;
    rdy_d  = acc;
    err_d  = acc && !mapped(paddr);
    if (acc && pwrite)
    begin
      if (paddr == `APS_CTRL_OFS)
        ctrl_d = {31'h0000_0000, pwdata[`APS_CTRL_RUN_BIT]};
      if (paddr == `APS_IRQ_MASK_OFS)
        msk_d = pwdata[`APS_IRQ_W-1:0];
      if (paddr == `APS_IRQ_STAT_OFS)
        ist_d = ist_q & ~pwdata[`APS_IRQ_W-1:0];
    end
    else if (acc)
    begin
      unique case (paddr)
        `APS_CTRL_OFS:     rd_d = ctrl_q;
        `APS_STATUS_OFS:   rd_d = status_word;
        `APS_IRQ_STAT_OFS: rd_d = {27'h000_0000, ist_q};
        `APS_IRQ_MASK_OFS: rd_d = {27'h000_0000, msk_q};
        default:           rd_d = 32'h0000_0000;
      endcase
    end
    ist_d = ist_d | events;
    irq_d = |(ist_d & msk_d);
  end

  // Registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `APS_CTRL_RESET_VAL;
      msk_q  <= `APS_IRQ_MASK_RST;
      ist_q  <= 5'h00;
      rd_q   <= 32'h0000_0000;
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
      irq_q  <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
      msk_q  <= msk_d;
      ist_q  <= ist_d;
      rd_q   <= rd_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
      irq_q  <= irq_d;
    end
  end

  assign prdata  = rd_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign run_en  = ctrl_q[`APS_CTRL_RUN_BIT];
  assign irq     = irq_q;

endmodule // aps_apb_regs
`default_nettype wire

/* File: aps_bus_model.sv */
// Bus voltage model that feeds the sequencer comparators.
`timescale 1ns/1ns
`default_nettype none

module aps_bus_model
(
  // Commanded bus state
  input  wire logic [9:0]           volts,
  input  wire logic                 flat,
  // Comparator indications
  output var  aps_pkg::aps_bus_type bus
);
  // ============================================================
  // Comparators
  // Fixed trip points without hysteresis, so the bench sets edges exactly.
  always_comb
  begin
    bus.above_400 = volts > 10'h190; // 400 V.
    bus.above_235 = volts > 10'h0EB; // 235 V.
    bus.above_205 = volts > 10'h0CD; // 205 V.
    bus.above_200 = volts > 10'h0C8; // 200 V.
    bus.above_190 = volts > 10'h0BE; // 190 V.
    bus.above_180 = volts > 10'h0B4; // 180 V.
    bus.settled   = flat;
  end
endmodule // aps_bus_model
`default_nettype wire

/* File: aps_delay_timer.sv */
// Cycle counter measuring one sequencing delay.
`timescale 1ns/1ns
`default_nettype none
`include "aps_regs.svh"

module aps_delay_timer
#(
  parameter int unsigned DELAY_CYC = `APS_DELAY_CYC
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Control
  input  wire logic run,
  input  wire logic clear,
  // Result
  output var  logic done
);

  logic [22:0] cnt_q;
  logic [22:0] cnt_d;
  logic        done_d;
  logic        done_q;

  // Counts while running; the clear wins so a restart starts fresh.
  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (clear)
    begin
      cnt_d  = 23'h000000;
      done_d = 1'b0;
    end
    else if (run && !done_q)
    begin
      if (cnt_q == 23'(DELAY_CYC - 1))
        done_d = 1'b1;
      else
        cnt_d = cnt_q + 23'h000001;
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 23'h000000;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule // aps_delay_timer
`default_nettype wire

/* File: aps_pkg.sv */
// Types shared by the power sequencer files.
package aps_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [2:0]
  {
    APS_INIT,
    APS_CHARGE,
    APS_BYPASS_WAIT,
    APS_ENABLED,
    APS_RUN,
    APS_FAIL_WARN
  } aps_state_type;

  // Bus-voltage threshold indications from the comparators.
  typedef struct packed
  {
    logic above_400;
    logic above_235;
    logic above_205;
    logic above_200;
    logic above_190;
    logic above_180;
    logic settled;
  } aps_bus_type;

  // Outputs towards the power stage.
  typedef struct packed
  {
    logic bypass_closed;
    logic doubler_on;
    logic conv_enable;
    logic power_good_flag_n;
  } aps_drive_type;

endpackage

/* File: aps_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef APS_REGS_SVH
`define APS_REGS_SVH

// ============================================================
// Register byte offsets
`define APS_CTRL_OFS     12'h000
`define APS_STATUS_OFS   12'h004
`define APS_IRQ_STAT_OFS 12'h008
`define APS_IRQ_MASK_OFS 12'h00C

// ============================================================
// Control register fields
`define APS_CTRL_RUN_BIT   0
`define APS_CTRL_RESET_VAL 32'h0000_0001

// ============================================================
// Status register fields
`define APS_ST_BYPASS_BIT  0
`define APS_ST_DOUBLER_BIT 1
`define APS_ST_ENABLE_BIT  2
`define APS_ST_PGOOD_BIT   3
`define APS_ST_STATE_LSB   4
`define APS_ST_STATE_MSB   6

// ============================================================
// Interrupt events: 0 converters on, 1 power good, 2 power fail
// warning, 3 converters off, 4 overvoltage
`define APS_IRQ_W        5
`define APS_IRQ_MASK_RST 5'h00

// ============================================================
// Delay between sequencing steps
`define APS_DELAY_MS     150
`define APS_CLK_HZ       50000000
`define APS_DELAY_CYC    ((`APS_DELAY_MS * `APS_CLK_HZ) / 1000)

`endif

/* File: aps_sequencer.sv */
// Power-up and power-down sequencer for an autoranging rectifier.
//
// How it works
// - Bypass and doubler switches open at power-up.
// - Start with converters disabled, power-good high.
// - Above 200 V, doubler stays off.
// - After settling, bypass closes only above 235 V.
// - Enable converters 150 ms after bypass.
// - Power good 150 ms after enabling.
// - Drop power good below 205 V.
// - Disable converters below 190 V.
// - After disable, restart the full sequence.
// - Recovery before disable rides through.
// - Above 400 V: disable and open bypass.
// - Below 180 V: open bypass.
`timescale 1ns/1ns
`default_nettype none
`include "aps_regs.svh"

module aps_sequencer
#(
  // Cycles in each sequencing delay; benches may shorten it.
  parameter int unsigned DELAY_CYC = `APS_DELAY_CYC
)
(
  // Clock, reset and enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // Bus-voltage comparator indications
  input  wire aps_pkg::aps_bus_type bus,
  // Power stage drive
  output var  logic                 bypass_closed,
  output var  logic                 doubler_on,
  output var  logic                 conv_enable,
  output var  logic                 power_good_flag_n,
  // Interrupt
  output var  logic                 irq
);

  // ============================================================
  // Sequencer state
  aps_pkg::aps_state_type  st_q, st_d;
  aps_pkg::aps_drive_type  drv_q, drv_d;
  logic                    t1_run, t2_run, t_clear;
  logic                    t1_done, t2_done;
  logic                    run_en;
  logic [`APS_IRQ_W-1:0]   ev;
  logic [31:0]             status_word;

  // ============================================================
  // Delay timers
  // Counted on pclk.
  aps_delay_timer
  #(
    .DELAY_CYC (DELAY_CYC)
  )
  u_t_enable
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (t1_run),
    .clear   (t_clear),
    .done    (t1_done)
  );

  aps_delay_timer
  #(
    .DELAY_CYC (DELAY_CYC)
  )
  u_t_good
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (t2_run),
    .clear   (t_clear),
    .done    (t2_done)
  );

  // ============================================================
  // Register file
  aps_apb_regs u_regs
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status_word (status_word),
    .events      (ev),
    .run_en      (run_en),
    .irq         (irq)
  );

  // Status word shows the live outputs and the state code.
  assign status_word = {25'h000_0000, st_q,
                        drv_q.power_good_flag_n, drv_q.conv_enable,
                        drv_q.doubler_on, drv_q.bypass_closed};

  // Timers run only in their own waiting states.
  assign t1_run = (st_q == aps_pkg::APS_BYPASS_WAIT);
  assign t2_run = (st_q == aps_pkg::APS_ENABLED);

  // ============================================================
  // Next-state logic
  always_comb
  begin
    st_d    = st_q;
    drv_d   = drv_q;
    t_clear = 1'b0;
    ev      = 5'h00;
    unique case (st_q)
      aps_pkg::APS_INIT:
      begin
        drv_d.bypass_closed     = 1'b0;
        drv_d.doubler_on        = 1'b0;
        drv_d.conv_enable       = 1'b0;
        drv_d.power_good_flag_n = 1'b1;
        t_clear = 1'b1;
        if (run_en)
          st_d = aps_pkg::APS_CHARGE;
      end
      aps_pkg::APS_CHARGE:
      begin
        // Doubler held off above 200 V.
        if (bus.settled)
        begin
          if (bus.above_200)
            drv_d.doubler_on = 1'b0;
          else
            drv_d.doubler_on = 1'b1;
        end
        // Bypass closes only above 235 V.
        // Doubler must already be settled; retry next cycle if it moved.
        if (bus.settled && bus.above_235 && !bus.above_400 &&
            (drv_q.doubler_on == !bus.above_200))
        begin
          drv_d.bypass_closed = 1'b1;
          st_d = aps_pkg::APS_BYPASS_WAIT;
        end
      end
      aps_pkg::APS_BYPASS_WAIT:
      begin
        if (t1_done)
        begin
          drv_d.conv_enable = 1'b1;
          ev[0] = 1'b1;
          st_d  = aps_pkg::APS_ENABLED;
        end
      end
      aps_pkg::APS_ENABLED:
      begin
        // Power good after the second delay.
        if (t2_done && bus.above_205)
        begin
          drv_d.power_good_flag_n = 1'b0;
          ev[1] = 1'b1;
          st_d  = aps_pkg::APS_RUN;
        end
        // A dip here only delays power good; the settle time still runs.
      end
      aps_pkg::APS_RUN:
      begin
        // Power good drops below 205 V.
        if (!bus.above_205)
        begin
          drv_d.power_good_flag_n = 1'b1;
          ev[2] = 1'b1;
          st_d  = aps_pkg::APS_FAIL_WARN;
        end
      end
      aps_pkg::APS_FAIL_WARN:
      begin
        // Recovery above 235 V rides through.
        if (bus.above_235)
        begin
          drv_d.power_good_flag_n = 1'b0;
          ev[1] = 1'b1;
          st_d  = aps_pkg::APS_RUN;
        end
      end
    endcase

    // Disable below 190 V once converters run.
    // Then restart from the initial state.
    if (drv_q.conv_enable && !bus.above_190)
    begin
      drv_d.conv_enable       = 1'b0;
      drv_d.power_good_flag_n = 1'b1;
      drv_d.bypass_closed     = 1'b0;
      ev[3] = 1'b1;
      st_d  = aps_pkg::APS_INIT;
    end

    // Fault below 180 V opens the bypass.
    if (drv_q.bypass_closed && !bus.above_180)
    begin
      drv_d.bypass_closed = 1'b0;
      if (!drv_q.conv_enable)
        st_d = aps_pkg::APS_INIT;
    end

    // Overvoltage disables and opens the bypass.
    // Restarting through init lets the thermistor pull the bus down.
    if (bus.above_400 && st_q != aps_pkg::APS_INIT)
    begin
      drv_d.conv_enable       = 1'b0;
      drv_d.bypass_closed     = 1'b0;
      drv_d.power_good_flag_n = 1'b1;
      ev[4] = 1'b1;
      st_d  = aps_pkg::APS_INIT;
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= aps_pkg::APS_INIT;
      drv_q <= 4'h1;                // Not-good flag high, all else off.
    end
    else if (ce)
    begin
      st_q  <= st_d;
      drv_q <= drv_d;
    end
  end

  // Outputs straight from the drive register.
  assign bypass_closed     = drv_q.bypass_closed;
  assign doubler_on        = drv_q.doubler_on;
  assign conv_enable       = drv_q.conv_enable;
  assign power_good_flag_n = drv_q.power_good_flag_n;

endmodule // aps_sequencer
`default_nettype wire

/* File: aps_sequencer_chk.sv */
// Checker for the power sequencer drive outputs.
`timescale 1ns/1ns
`default_nettype none
`include "aps_regs.svh"

module aps_sequencer_chk
#(
  parameter int unsigned DELAY_CYC = `APS_DELAY_CYC
)
(
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Bus indications and drive
  input wire aps_pkg::aps_bus_type bus,
  input wire logic                 bypass_closed,
  input wire logic                 doubler_on,
  input wire logic                 conv_enable,
  input wire logic                 power_good_flag_n
);
  localparam int DLY = DELAY_CYC;
  logic [31:0] en_cnt_q, en_cnt_d, pg_cnt_q, pg_cnt_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ============================================================
  // Delay counters
  // Cycles since the bypass closed and since the converters came on.
  always_comb
  begin
    en_cnt_d = (bypass_closed && !conv_enable) ? en_cnt_q + 32'h1 : 32'h0;
    pg_cnt_d = conv_enable ? pg_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_cnt_q <= 32'h0;
      pg_cnt_q <= 32'h0;
    end
    else
    begin
      en_cnt_q <= en_cnt_d;
      pg_cnt_q <= pg_cnt_d;
    end
  end

  // ============================================================
  // Properties
  sequence s_close;
    !bypass_closed ##1 bypass_closed;
  endsequence
  property p_init;
    $rose(presetn) |-> !bypass_closed && !doubler_on && !conv_enable
      && power_good_flag_n;
  endproperty
  property p_dbl;
    $rose(doubler_on) |-> !$past(bus.above_200);
  endproperty
  property p_byp;
    s_close |-> $past(bus.settled && bus.above_235);
  endproperty
  property p_order;
    s_close |-> $stable(doubler_on);
  endproperty
  property p_en_dly;
    $rose(conv_enable) |-> en_cnt_q == DLY + 1;
  endproperty
  property p_pg_dly;
    $fell(power_good_flag_n) |-> pg_cnt_q >= DLY + 1;
  endproperty
  property p_pg_drop;
    !power_good_flag_n && !bus.above_205 |=> power_good_flag_n;
  endproperty
  property p_off;
    conv_enable && !bus.above_190 |=> !conv_enable && !bypass_closed
      && power_good_flag_n;
  endproperty
  property p_ride;
    conv_enable && bus.above_190 && !bus.above_400 |=> conv_enable;
  endproperty
  property p_ov;
    bus.above_400 |=> !conv_enable && !bypass_closed;
  endproperty
  property p_low;
    bypass_closed && !bus.above_180 |=> !bypass_closed;
  endproperty
  a_init: assert property (p_init) else $error("bad reset drive");
  a_dbl: assert property (p_dbl) else $error("doubler above 200");
  a_byp: assert property (p_byp) else $error("early bypass");
  a_order: assert property (p_order) else $error("doubler late");
  a_en_dly: assert property (p_en_dly) else $error("enable delay");
  a_pg_dly: assert property (p_pg_dly) else $error("good delay");
  a_pg_drop: assert property (p_pg_drop) else $error("good held");
  a_off: assert property (p_off) else $error("no disable");
  a_ride: assert property (p_ride) else $error("ride lost");
  a_ov: assert property (p_ov) else $error("overvoltage");
  a_low: assert property (p_low) else $error("low bus bypass");
endmodule // aps_sequencer_chk

bind aps_sequencer aps_sequencer_chk #(.DELAY_CYC(DELAY_CYC)) u_chk
(
  .pclk(pclk), .presetn(presetn), .bus(bus),
  .bypass_closed(bypass_closed), .doubler_on(doubler_on),
  .conv_enable(conv_enable), .power_good_flag_n(power_good_flag_n)
);
`default_nettype wire

/* File: autorange_power_sequencer_bench.sv */
// Self-checking bench for the power sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "aps_regs.svh"

module autorange_power_sequencer_bench;
  // Short delays keep the run small; the sequencing logic is the same.
  localparam int DLY = 20;
  typedef struct
  {
    logic [9:0] v;
    logic       flat;
    int         wait_c;
    logic [3:0] exp;
  } aps_row_type;
  logic                 pclk, presetn, psel, penable, pwrite, flat;
  logic                 pready, pslverr, irq, err;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [9:0]           volts;
  logic                 bypass_closed, doubler_on, conv_enable;
  logic                 power_good_flag_n;
  logic [2:0]           obs;
  aps_pkg::aps_bus_type bus;
  int                   n_errors, n_compared, k;
  // Volts, settled, cycles, then bypass, doubler, enable, flag_n.
  aps_row_type rows [9] = '{
    '{10'h096, 1'b0, 5, 4'b0001}, // charging
    '{10'h0A0, 1'b1, 4, 4'b0101}, // doubler first
    '{10'h0C8, 1'b1, 4, 4'b1011}, // good dropped
    '{10'h140, 1'b1, 4, 4'b1010}, // ride through
    '{10'h0B9, 1'b0, 4, 4'b0001}, // converters off
    '{10'h0FA, 1'b1, 12, 4'b1001}, // restart
    '{10'h19A, 1'b1, 4, 4'b0001}, // overvoltage
    '{10'h0FA, 1'b1, 6, 4'b1001}, // restart again
    '{10'h0AA, 1'b0, 4, 4'b0001}}; // low bus

  assign obs = {!power_good_flag_n, conv_enable, bypass_closed};

  // Free running 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The clock enable stays high; freezing is not part of these checks.
  aps_sequencer #(.DELAY_CYC(DLY)) u_dut
  (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus),
    .bypass_closed(bypass_closed), .doubler_on(doubler_on),
    .conv_enable(conv_enable), .power_good_flag_n(power_good_flag_n),
    .irq(irq)
  );
  aps_bus_model u_model (.volts(volts), .flat(flat), .bus(bus));

  // ============================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_rows(input int lo, hi);
    for (int i = lo; i <= hi; i++)
    begin
      @(posedge pclk);
      volts <= rows[i].v;
      flat <= rows[i].flat;
      repeat (rows[i].wait_c) @(negedge pclk);
      chk($sformatf("row %0d", i), {28'h0, rows[i].exp},
          {28'h0, bypass_closed, doubler_on, conv_enable, power_good_flag_n});
    end
  endtask

  // Counts cycles until the selected output turns active.
  task automatic until_set(input int sel, lim, output int n);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (obs[sel] !== 1'b1 && n < lim);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, flat} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    volts = 10'h000;
    repeat (4) @(negedge pclk);
    chk("reset drive", 32'h1, {28'h0, obs, power_good_flag_n});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `APS_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, `APS_IRQ_MASK_OFS, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    run_rows(0, 1);
    // Exact sequencing delays measured from each preceding step.
    @(posedge pclk);
    volts <= 10'h140;
    until_set(0, 8, k);
    until_set(1, DLY + 8, k);
    chk("enable delay", DLY + 1, k);
    until_set(2, DLY + 8, k);
    chk("good delay", DLY + 1, k);
    apb(1'b0, `APS_STATUS_OFS, 32'h0);
    chk("status", 32'h45, rd);
    apb(1'b0, `APS_IRQ_STAT_OFS, 32'h0);
    chk("irq status", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `APS_IRQ_MASK_OFS, 32'h1F);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `APS_IRQ_STAT_OFS, 32'h3);
    repeat (2) @(negedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    run_rows(2, 8);
    wrap_up();
  end

  // Watchdog sized for two full delays plus register traffic.
  initial
  begin
    repeat (2 * DLY + 5000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
endmodule // autorange_power_sequencer_bench
`default_nettype wire
